// ### core/desc_table_unit.v
// Descriptor table protection unit: table registers, selector lookup,
// system and gate descriptor decode, and four hidden segment caches.
// Assumes a memory port that holds each read until a one-cycle ack,
// and an APB master that never issues a command while busy is set.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/100ps
`include "desc_table_consts.vh"

module desc_table_unit #(
  parameter ADDR_W = 24,
  parameter NSEG = 4
) (
  // Clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output wire o_pslverr,
  output reg [31:0] o_prdata,
  // System memory read port
  output reg o_mem_req,
  output reg o_mem_lock,
  output reg [ADDR_W-1:0] o_mem_addr,
  input wire i_mem_ack,
  input wire [15:0] i_mem_rdata,
  // Segment reference port
  input wire [1:0] i_ref_seg,
  input wire [15:0] i_ref_off,
  output reg [ADDR_W-1:0] o_ref_addr,
  output reg o_ref_fault,
  // Flags toward the execution unit
  output wire o_if_flag,
  output wire o_busy
);

  localparam S_IDLE = 2'h0;
  localparam S_RD = 2'h1;
  localparam S_EVAL = 2'h2;

  reg [1:0] state_q;
  reg phase_q;
  reg [1:0] op_q;
  reg [1:0] seg_q;
  reg [15:0] sel_q;
  reg [1:0] cpl_q;
  reg if_q;
  reg [15:0] oper_limit_q;
  reg [23:0] oper_base_q;
  reg [23:0] gt_base_q;
  reg [15:0] gt_limit_q;
  reg [23:0] lt_base_q;
  reg [15:0] lt_limit_q;
  reg [15:0] desc_q [0:2];
  reg [2:0] wcnt_q;
  reg done_q;
  reg fault_q;
  reg [7:0] vec_q;
  reg [2:0] gtype_q;
  reg [15:0] gofs_q;
  reg [15:0] gsel_q;
  reg [15:0] entry_q;
  reg [4:0] copy_q;
  reg [23:0] cbase_q [0:NSEG-1];
  reg [15:0] climit_q [0:NSEG-1];
  reg [NSEG-1:0] cvalid_q;

  // Table lookup: {outside_limit, entry_address}
  function [24:0] lookup;
    input [15:0] sel;
    input [23:0] gbase;
    input [15:0] glimit;
    input [23:0] lbase;
    input [15:0] llimit;
    reg [23:0] base;
    reg [16:0] last;
    reg [15:0] lim;
    begin
      base = sel[`SEL_TI_BIT] ? lbase : gbase;
      lim = sel[`SEL_TI_BIT] ? llimit : glimit;
      // 13-bit index, eight bytes per entry
      last = {1'b0, sel[15:`SEL_IDX_LSB], 3'b111};
      lookup[24] = (last > {1'b0, lim});
      lookup[23:0] = base + {8'h00, sel[15:`SEL_IDX_LSB], 3'b000};
    end
  endfunction

  wire [24:0] sel_look = lookup(sel_q, gt_base_q, gt_limit_q, lt_base_q, lt_limit_q);
  wire [24:0] gate_look = lookup(desc_q[1], gt_base_q, gt_limit_q, lt_base_q, lt_limit_q);

  // Decoded access byte of the descriptor just fetched
  wire [15:0] acc_w = desc_q[2];
  wire acc_p = acc_w[`ACC_P_BIT];
  wire [1:0] acc_dpl = acc_w[`ACC_DPL_LSB+1:`ACC_DPL_LSB];
  wire acc_sys = ~acc_w[`ACC_S_BIT];
  wire acc_code = acc_w[`ACC_S_BIT] & acc_w[`ACC_E_BIT];
  wire [3:0] acc_type = acc_w[`ACC_TYPE_LSB+3:`ACC_TYPE_LSB];
  wire is_gate = acc_sys & (acc_type[3:2] == 2'b01);
  wire is_tss = acc_sys & ((acc_type == {1'b0, `TYPE_TSS_AVAIL})
    | (acc_type == {1'b0, `TYPE_TSS_BUSY}));
  wire is_lt = acc_sys & (acc_type == {1'b0, `TYPE_LOCAL_TABLE});
  wire [2:0] gtype_w = acc_type[2:0];
  // Global table refuses interrupt/trap gates; local table only call/task gates
  wire gate_bad_tbl = sel_q[`SEL_TI_BIT]
    ? ~((gtype_w == `TYPE_CALL_GATE) | (gtype_w == `TYPE_TASK_GATE))
    : ((gtype_w == `TYPE_INT_GATE) | (gtype_w == `TYPE_TRAP_GATE));

  // APB: zero-wait, read data captured during the setup phase
  wire setup = i_psel & ~i_penable;
  wire wr_acc = i_psel & i_penable & i_pwrite;
  reg mapped;
  reg [31:0] rd_mux;

  always @*
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (i_paddr)
      `OFF_CMD: rd_mux = {28'h000_0000, seg_q, op_q};
      `OFF_SEL: rd_mux = {16'h0000, sel_q};
      `OFF_CTRL: rd_mux = {23'h00_0000, if_q, 6'h00, cpl_q};
      `OFF_OPER_LIMIT: rd_mux = {16'h0000, oper_limit_q};
      `OFF_OPER_BASE: rd_mux = {8'h00, oper_base_q};
      `OFF_STATUS: rd_mux = {16'h0000, vec_q, 4'h0, fault_q, done_q, 1'b0, o_busy};
      `OFF_GT_BASE: rd_mux = {8'h00, gt_base_q};
      `OFF_GT_LIMIT: rd_mux = {16'h0000, gt_limit_q};
      `OFF_LT_BASE: rd_mux = {8'h00, lt_base_q};
      `OFF_LT_LIMIT: rd_mux = {16'h0000, lt_limit_q};
      `OFF_GATE_OFS: rd_mux = {16'h0000, entry_q};
      `OFF_GATE_INFO: rd_mux = {8'h00, copy_q, gtype_q, gsel_q};
      default: mapped = 1'b0;
    endcase
  end

  reg slverr_q;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & slverr_q;
  assign o_busy = (state_q != S_IDLE);
  assign o_if_flag = if_q;

  always @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_prdata <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end
    else if (setup)
    begin
      o_prdata <= i_pwrite ? 32'h0000_0000 : rd_mux;
      slverr_q <= ~mapped;
    end
  end

  // Software-writable operand and privilege registers
  wire cmd_wr = wr_acc & (i_paddr == `OFF_CMD) & ~o_busy;
  reg if_clr;

  always @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      sel_q <= 16'h0000;
      cpl_q <= 2'h0;
      oper_limit_q <= `RST_LIMIT;
      oper_base_q <= `RST_BASE;
      if_q <= `RST_IF;
    end
    else
    begin
      if (wr_acc & (i_paddr == `OFF_SEL) & ~o_busy)
        sel_q <= i_pwdata[15:0];
      if (wr_acc & (i_paddr == `OFF_OPER_LIMIT))
        oper_limit_q <= i_pwdata[15:0];
      if (wr_acc & (i_paddr == `OFF_OPER_BASE))
        oper_base_q <= i_pwdata[23:0];
      if (wr_acc & (i_paddr == `OFF_CTRL))
      begin
        cpl_q <= i_pwdata[1:0];
        if_q <= i_pwdata[8];
      end
      // Hardware clear wins over a software write in the same cycle
      if (if_clr)
        if_q <= 1'b0;
    end
  end

  // Segment reference translation, fed only from the caches
  always @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_ref_addr <= 24'h00_0000;
      o_ref_fault <= 1'b0;
    end
    else
    begin
      o_ref_addr <= cbase_q[i_ref_seg] + {8'h00, i_ref_off};
      o_ref_fault <= ~cvalid_q[i_ref_seg] | (i_ref_off > climit_q[i_ref_seg]);
    end
  end

  // Command engine
  integer k;

  always @(posedge i_clk)
  begin
    if_clr <= 1'b0;
    if (!i_reset_n)
    begin
      state_q <= S_IDLE;
      phase_q <= 1'b0;
      op_q <= `OP_LOAD_SEG;
      seg_q <= 2'h0;
      gt_base_q <= `RST_BASE;
      gt_limit_q <= `RST_LIMIT;
      lt_base_q <= `RST_BASE;
      lt_limit_q <= `RST_LIMIT;
      wcnt_q <= 3'h0;
      done_q <= 1'b0;
      fault_q <= 1'b0;
      vec_q <= 8'h00;
      gtype_q <= 3'h0;
      gofs_q <= 16'h0000;
      gsel_q <= 16'h0000;
      entry_q <= 16'h0000;
      copy_q <= 5'h00;
      cvalid_q <= {NSEG{1'b0}};
      o_mem_req <= 1'b0;
      o_mem_lock <= 1'b0;
      o_mem_addr <= {ADDR_W{1'b0}};
      if_clr <= 1'b0;
      for (k = 0; k < 3; k = k + 1)
        desc_q[k] <= 16'h0000;
      for (k = 0; k < NSEG; k = k + 1)
      begin
        cbase_q[k] <= `RST_BASE;
        climit_q[k] <= `RST_LIMIT;
      end
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          if (cmd_wr)
          begin
            op_q <= i_pwdata[1:0];
            seg_q <= i_pwdata[3:2];
            done_q <= 1'b0;
            fault_q <= 1'b0;
            vec_q <= 8'h00;
            phase_q <= 1'b0;
            if ((i_pwdata[1:0] == `OP_LOAD_GT) | (i_pwdata[1:0] == `OP_LOAD_LT))
            begin
              if (cpl_q != 2'h0)
              begin
                fault_q <= 1'b1;
                vec_q <= `EXC_GENERAL;
                done_q <= 1'b1;
              end
              else if (i_pwdata[1:0] == `OP_LOAD_GT)
              begin
                gt_limit_q <= oper_limit_q;
                gt_base_q <= oper_base_q;
                done_q <= 1'b1;
              end
              else if (sel_q[`SEL_TI_BIT] | sel_look[24])
              begin
                // A local table descriptor must itself live in the global table
                fault_q <= 1'b1;
                vec_q <= `EXC_GENERAL;
                done_q <= 1'b1;
              end
              else
              begin
                o_mem_addr <= sel_look[23:0];
                state_q <= S_RD;
              end
            end
            else if (sel_look[24])
            begin
              fault_q <= 1'b1;
              vec_q <= `EXC_GENERAL;
              done_q <= 1'b1;
            end
            else
            begin
              o_mem_addr <= sel_look[23:0];
              state_q <= S_RD;
            end
            wcnt_q <= 3'h0;
          end
        end
        S_RD:
        begin
          // Lock covers all four words so no other master splits the entry
          o_mem_req <= 1'b1;
          o_mem_lock <= 1'b1;
          if (o_mem_req & i_mem_ack)
          begin
            if (wcnt_q < 3'h3)
              desc_q[wcnt_q[1:0]] <= i_mem_rdata;
            wcnt_q <= wcnt_q + 3'h1;
            o_mem_addr <= o_mem_addr + 24'h00_0002;
            if (wcnt_q == `DESC_WORDS - 3'h1)
            begin
              o_mem_req <= 1'b0;
              o_mem_lock <= 1'b0;
              state_q <= S_EVAL;
            end
            else
              o_mem_req <= 1'b0;
          end
        end
        S_EVAL:
        begin
          state_q <= S_IDLE;
          done_q <= 1'b1;
          vec_q <= `EXC_GENERAL;
          fault_q <= 1'b1;
          if (!phase_q)
          begin
            case (op_q)
              `OP_LOAD_SEG:
              begin
                if (acc_sys)
                  vec_q <= `EXC_GENERAL;
                else if (!acc_p)
                  vec_q <= `EXC_NOT_PRESENT;
                else
                begin
                  fault_q <= 1'b0;
                  vec_q <= 8'h00;
                  cbase_q[seg_q] <= {desc_q[2][7:0], desc_q[1]};
                  climit_q[seg_q] <= desc_q[0];
                  cvalid_q[seg_q] <= 1'b1;
                end
              end
              `OP_LOAD_LT:
              begin
                // Privilege field of a local table descriptor is not examined
                if (!is_lt)
                  vec_q <= `EXC_GENERAL;
                else if (!acc_p)
                  vec_q <= `EXC_NOT_PRESENT;
                else
                begin
                  fault_q <= 1'b0;
                  vec_q <= 8'h00;
                  lt_base_q <= {desc_q[2][7:0], desc_q[1]};
                  lt_limit_q <= desc_q[0];
                end
              end
              default:
              begin
                if (!is_gate | gate_bad_tbl)
                  vec_q <= `EXC_GENERAL;
                else if (!acc_p)
                  vec_q <= `EXC_NOT_PRESENT;
                else if (gate_look[24])
                  vec_q <= `EXC_GENERAL;
                else
                begin
                  fault_q <= 1'b0;
                  vec_q <= 8'h00;
                  done_q <= 1'b0;
                  gtype_q <= gtype_w;
                  gofs_q <= desc_q[0];
                  gsel_q <= desc_q[1];
                  copy_q <= desc_q[2][`GATE_WC_LSB+4:`GATE_WC_LSB];
                  o_mem_addr <= gate_look[23:0];
                  wcnt_q <= 3'h0;
                  phase_q <= 1'b1;
                  state_q <= S_RD;
                end
              end
            endcase
          end
          else if (gtype_q == `TYPE_TASK_GATE)
          begin
            if (!is_tss)
              vec_q <= `EXC_GENERAL;
            else if (acc_dpl < cpl_q)
              vec_q <= `EXC_GENERAL;
            else if (!acc_p)
              vec_q <= `EXC_NOT_PRESENT;
            else
            begin
              fault_q <= 1'b0;
              vec_q <= 8'h00;
              entry_q <= 16'h0000;
              copy_q <= 5'h00;
            end
          end
          else
          begin
            if (!acc_code)
              vec_q <= `EXC_GENERAL;
            else if (!acc_p)
              vec_q <= `EXC_NOT_PRESENT;
            else
            begin
              fault_q <= 1'b0;
              vec_q <= 8'h00;
              entry_q <= gofs_q;
              // Word count matters only for a call gate that changes level
              if ((gtype_q != `TYPE_CALL_GATE) | (acc_dpl == cpl_q))
                copy_q <= 5'h00;
              if (gtype_q == `TYPE_INT_GATE)
                if_clr <= 1'b1;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

endmodule // desc_table_unit

// ### include/desc_table_consts.vh
// Constants for the descriptor table protection unit: APB offsets,
// descriptor field positions, type codes, exception vectors and reset values.
// Assumes a 32-bit APB bus and a 16-bit system memory read port.
`ifndef DESC_TABLE_CONSTS_VH
`define DESC_TABLE_CONSTS_VH

// APB register byte offsets
`define OFF_CMD 8'h00
`define OFF_SEL 8'h04
`define OFF_CTRL 8'h08
`define OFF_OPER_LIMIT 8'h0C
`define OFF_OPER_BASE 8'h10
`define OFF_STATUS 8'h14
`define OFF_GT_BASE 8'h18
`define OFF_GT_LIMIT 8'h1C
`define OFF_LT_BASE 8'h20
`define OFF_LT_LIMIT 8'h24
`define OFF_GATE_OFS 8'h28
`define OFF_GATE_INFO 8'h2C

// Commands written to CMD[1:0], segment number in CMD[3:2]
`define OP_LOAD_SEG 2'h0
`define OP_LOAD_GT 2'h1
`define OP_LOAD_LT 2'h2
`define OP_GATE 2'h3

// Selector fields
`define SEL_RPL_LSB 0
`define SEL_TI_BIT 2
`define SEL_IDX_LSB 3

// Access byte and gate word count fields, inside descriptor word 2
`define ACC_P_BIT 15
`define ACC_DPL_LSB 13
`define ACC_S_BIT 12
`define ACC_E_BIT 11
`define ACC_TYPE_LSB 8
`define GATE_WC_LSB 0

// Type codes of system control descriptors
`define TYPE_TSS_AVAIL 3'h1
`define TYPE_LOCAL_TABLE 3'h2
`define TYPE_TSS_BUSY 3'h3
`define TYPE_CALL_GATE 3'h4
`define TYPE_TASK_GATE 3'h5
`define TYPE_INT_GATE 3'h6
`define TYPE_TRAP_GATE 3'h7

// Exception vectors
`define EXC_NOT_PRESENT 8'h0B
`define EXC_GENERAL 8'h0D

// Geometry and reset values
`define ENTRY_BYTES 24'h00_0008
`define DESC_WORDS 3'h4
`define RST_BASE 24'h00_0000
`define RST_LIMIT 16'h0000
`define RST_IF 1'b1

`endif

// ### tb/desc_mem_model.sv
// Behavioural system memory that holds the descriptor tables.
// Assumes one read at a time, with the request held until the one-cycle ack.
`timescale 1ns/100ps

module desc_mem_model (
  // Clock
  input wire i_clk,
  // Read port from the unit
  input wire i_req,
  input wire [23:0] i_addr,
  input wire [3:0] i_wait,
  output reg o_ack,
  output reg [15:0] o_rdata
);
  reg [15:0] mem [0:255];
  reg [3:0] wait_q;

  initial
  begin
    o_ack = 1'b0;
    o_rdata = 16'h0000;
    wait_q = 4'h0;
  end

  // Data toggles outside the ack cycle, so a late sample cannot pass by luck
  always @(posedge i_clk)
  begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack)
    begin
      if (wait_q >= i_wait)
      begin
        o_ack <= 1'b1;
        o_rdata <= mem[i_addr[8:1]];
        wait_q <= 4'h0;
      end
      else
      begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule // desc_mem_model

// ### tb/desc_table_unit_properties.sv
// Concurrent checks on the ports of the descriptor table unit.
// Assumes the unit's single clock and synchronous active-low reset.
`timescale 1ns/100ps
`include "desc_table_consts.vh"

module desc_table_unit_properties #(
  parameter ADDR_W = 24
) (
  // Clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // APB
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  // Memory port
  input wire o_mem_req,
  input wire o_mem_lock,
  input wire [ADDR_W-1:0] o_mem_addr,
  input wire i_mem_ack,
  // Status
  input wire o_ref_fault,
  input wire o_if_flag,
  input wire o_busy
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  reg ctrl_wr_q;

  always @(posedge i_clk)
  begin
    if (!i_reset_n)
      ctrl_wr_q <= 1'b0;
    else
      ctrl_wr_q <= i_psel && i_penable && i_pwrite && (i_paddr == `OFF_CTRL);
  end

  property p_lock_with_req;
    o_mem_req |-> o_mem_lock;
  endproperty
  a_lock_with_req: assert property (p_lock_with_req) else $error("read without lock");

  property p_lock_through;
    $rose(o_mem_req) && (o_mem_addr[2:1] != 2'b00) |-> $past(o_mem_lock);
  endproperty
  a_lock_through: assert property (p_lock_through) else $error("lock dropped");

  property p_req_holds;
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr);
  endproperty
  a_req_holds: assert property (p_req_holds) else $error("request moved early");

  property p_word_align;
    o_mem_req |-> !o_mem_addr[0];
  endproperty
  a_word_align: assert property (p_word_align) else $error("odd word address");

  property p_no_mem_idle;
    !o_busy |-> !o_mem_req && !o_mem_lock;
  endproperty
  a_no_mem_idle: assert property (p_no_mem_idle) else $error("memory used while idle");

  property p_busy_bound;
    $rose(o_busy) |-> ##[1:400] !o_busy;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("command never ends");

  property p_if_fall;
    $fell(o_if_flag) |-> $past(o_busy, 2) || ctrl_wr_q;
  endproperty
  a_if_fall: assert property (p_if_fall) else $error("flag cleared without cause");

  property p_reset_quiet;
    $rose(i_reset_n) |-> !o_busy && !o_mem_req && o_if_flag;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("bad reset state");

  property p_fresh_fault;
    $rose(i_reset_n) |=> o_ref_fault;
  endproperty
  a_fresh_fault: assert property (p_fresh_fault) else $error("cache valid after reset");
endmodule // desc_table_unit_properties

bind desc_table_unit desc_table_unit_properties #(.ADDR_W(ADDR_W)) u_props (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_mem_req(o_mem_req), .o_mem_lock(o_mem_lock),
  .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack), .o_ref_fault(o_ref_fault),
  .o_if_flag(o_if_flag), .o_busy(o_busy)
);

// ### tb/descriptor_table_protection_tb_top.sv
// Self-checking bench for the descriptor table unit: table loads, gate
// decode, segment caches, refused commands and a second reset.
// Assumes the behavioural memory model and the bound checker.
`timescale 1ns/100ps
`include "desc_table_consts.vh"

module descriptor_table_protection_tb_top;
  typedef struct packed {
    logic [1:0] cpl;
    logic [1:0] op;
    logic [1:0] seg;
    logic [15:0] sel;
    logic [7:0] vec;
    logic [15:0] ofs;
    logic [23:0] info;
  } row_t;

  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0000_0000;
  reg [1:0] ref_seg = 2'h0;
  reg [15:0] ref_off = 16'h0000;
  reg [3:0] mem_wait = 4'h0;
  wire pready;
  wire pslverr;
  wire [31:0] prdata;
  wire mem_req;
  wire mem_lock;
  wire [23:0] mem_addr;
  wire mem_ack;
  wire [15:0] mem_rdata;
  wire [23:0] ref_addr;
  wire ref_fault;
  wire if_flag;
  wire busy;
  reg [31:0] rd;
  reg err;
  integer num_errors = 0;
  integer compares = 0;
  integer i;
  row_t rows [0:15];

  always #10 clk = ~clk;

  desc_table_unit dut (
    .i_clk(clk), .i_reset_n(reset_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_prdata(prdata), .o_mem_req(mem_req), .o_mem_lock(mem_lock),
    .o_mem_addr(mem_addr), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
    .i_ref_seg(ref_seg), .i_ref_off(ref_off), .o_ref_addr(ref_addr),
    .o_ref_fault(ref_fault), .o_if_flag(if_flag), .o_busy(busy)
  );

  desc_mem_model u_mem (
    .i_clk(clk), .i_req(mem_req), .i_addr(mem_addr), .i_wait(mem_wait),
    .o_ack(mem_ack), .o_rdata(mem_rdata)
  );

  task end_sim;
    begin
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  task bail;
    begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      end_sim();
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task apb(input wr, input [7:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      n = 0;
      while (pready !== 1'b1 && n < 20)
      begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 20)
        bail();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask

  task rd_chk(input [7:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
    end
  endtask

  task wait_done;
    integer n;
    begin
      n = 0;
      rd = 32'h0000_0000;
      while (rd[2] !== 1'b1 && n < 100)
      begin
        apb(1'b0, `OFF_STATUS, 32'h0000_0000);
        n = n + 1;
      end
      if (n == 100)
        bail();
    end
  endtask

  task run_cmd(input [1:0] op, input [1:0] seg, input [15:0] sel);
    begin
      apb(1'b1, `OFF_SEL, {16'h0000, sel});
      apb(1'b1, `OFF_CMD, {28'h000_0000, seg, op});
      wait_done();
    end
  endtask

  task ref_chk(input [1:0] s, input [15:0] off, input [23:0] a, input f);
    begin
      ref_seg <= s;
      ref_off <= off;
      @(posedge clk);
      @(posedge clk);
      chk({31'h0000_0000, ref_fault}, {31'h0000_0000, f});
      if (!f)
        chk({8'h00, ref_addr}, {8'h00, a});
    end
  endtask

  // Word 3 of every entry is garbage so that a stray use of it shows
  task put(input [23:0] a, input [15:0] w0, input [15:0] w1, input [15:0] w2);
    begin
      u_mem.mem[a[8:1]] = w0;
      u_mem.mem[a[8:1] + 8'h01] = w1;
      u_mem.mem[a[8:1] + 8'h02] = w2;
      u_mem.mem[a[8:1] + 8'h03] = 16'hFFFF;
    end
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    bail();
  end

  initial
  begin
    rows[0] = '{2'h0, `OP_LOAD_GT, 2'h0, 16'h0000, 8'h00, 16'h0000, 24'h00_0000};
    rows[1] = '{2'h0, `OP_LOAD_LT, 2'h0, 16'h0008, 8'h00, 16'h0000, 24'h00_0000};
    rows[2] = '{2'h0, `OP_LOAD_LT, 2'h0, 16'h0010, 8'h0D, 16'h0000, 24'h00_0000};
    rows[3] = '{2'h0, `OP_LOAD_SEG, 2'h2, 16'h0010, 8'h00, 16'h0000, 24'h00_0000};
    rows[4] = '{2'h0, `OP_LOAD_SEG, 2'h3, 16'h0004, 8'h00, 16'h0000, 24'h00_0000};
    rows[5] = '{2'h0, `OP_LOAD_SEG, 2'h1, 16'h0020, 8'h0D, 16'h0000, 24'h00_0000};
    rows[6] = '{2'h0, `OP_GATE, 2'h0, 16'h0020, 8'h00, 16'h1234, 24'h04_0018};
    rows[7] = '{2'h3, `OP_GATE, 2'h0, 16'h0020, 8'h00, 16'h1234, 24'h1C_0018};
    rows[8] = '{2'h0, `OP_GATE, 2'h0, 16'h0028, 8'h00, 16'h0000, 24'h05_0030};
    rows[9] = '{2'h3, `OP_GATE, 2'h0, 16'h0028, 8'h0D, 16'h0000, 24'h00_0000};
    rows[10] = '{2'h0, `OP_GATE, 2'h0, 16'h0038, 8'h0D, 16'h0000, 24'h00_0000};
    rows[11] = '{2'h0, `OP_GATE, 2'h0, 16'h000C, 8'h0B, 16'h0000, 24'h00_0000};
    rows[12] = '{2'h0, `OP_GATE, 2'h0, 16'h0014, 8'h0D, 16'h0000, 24'h00_0000};
    rows[13] = '{2'h0, `OP_GATE, 2'h0, 16'h001C, 8'h0D, 16'h0000, 24'h00_0000};
    rows[14] = '{2'h0, `OP_GATE, 2'h0, 16'h0040, 8'h0D, 16'h0000, 24'h00_0000};
    rows[15] = '{2'h0, `OP_LOAD_SEG, 2'h0, 16'h0024, 8'h0D, 16'h0000, 24'h00_0000};
    put(24'h00_0048, 16'h001F, 16'h0100, 16'h8200);
    put(24'h00_0050, 16'h0FFF, 16'h2000, 16'h9305);
    put(24'h00_0058, 16'hFFFF, 16'h0000, 16'h9A01);
    put(24'h00_0060, 16'h1234, 16'h0018, 16'hE403);
    put(24'h00_0068, 16'h5555, 16'h0030, 16'hE500);
    put(24'h00_0070, 16'h002B, 16'h3000, 16'h8100);
    put(24'h00_0078, 16'h0000, 16'h0018, 16'hE600);
    put(24'h00_0100, 16'h00FF, 16'h4000, 16'h9300);
    put(24'h00_0108, 16'h0000, 16'h0018, 16'h6403);
    put(24'h00_0110, 16'h0000, 16'h0010, 16'hE400);
    put(24'h00_0118, 16'h0000, 16'h0018, 16'hE700);
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    apb(1'b1, `OFF_OPER_LIMIT, 32'h0000_003F);
    apb(1'b1, `OFF_OPER_BASE, 32'h0000_0040);
    for (i = 0; i < 16; i = i + 1)
    begin
      mem_wait <= {1'b0, i[1:0], 1'b0};
      apb(1'b1, `OFF_CTRL, {23'h00_0000, 1'b1, 6'h00, rows[i].cpl});
      run_cmd(rows[i].op, rows[i].seg, rows[i].sel);
      chk({31'h0000_0000, rd[3]}, {31'h0000_0000, rows[i].vec != 8'h00});
      chk({24'h00_0000, rd[15:8]}, {24'h00_0000, rows[i].vec});
      if (rows[i].op == `OP_GATE && rows[i].vec == 8'h00)
      begin
        rd_chk(`OFF_GATE_OFS, {16'h0000, rows[i].ofs});
        rd_chk(`OFF_GATE_INFO, {8'h00, rows[i].info});
      end
    end
    rd_chk(`OFF_GT_BASE, 32'h0000_0040);
    rd_chk(`OFF_GT_LIMIT, 32'h0000_003F);
    rd_chk(`OFF_LT_BASE, 32'h0000_0100);
    rd_chk(`OFF_LT_LIMIT, 32'h0000_001F);
    chk({31'h0000_0000, if_flag}, 32'h0000_0001);
    apb(1'b1, `OFF_CTRL, 32'h0000_0103);
    apb(1'b1, `OFF_OPER_BASE, 32'h0000_0080);
    run_cmd(`OP_LOAD_GT, 2'h0, 16'h0000);
    chk({24'h00_0000, rd[15:8]}, 32'h0000_000D);
    rd_chk(`OFF_GT_BASE, 32'h0000_0040);
    apb(1'b1, `OFF_CTRL, 32'h0000_0000);
    chk({31'h0000_0000, if_flag}, 32'h0000_0000);
    apb(1'b1, `OFF_CTRL, 32'h0000_0100);
    ref_chk(2'h2, 16'h0FFF, 24'h05_2FFF, 1'b0);
    ref_chk(2'h2, 16'h1000, 24'h00_0000, 1'b1);
    ref_chk(2'h3, 16'h00FF, 24'h00_40FF, 1'b0);
    ref_chk(2'h1, 16'h0000, 24'h00_0000, 1'b1);
    ref_chk(2'h0, 16'h0000, 24'h00_0000, 1'b1);
    // Table entry changes must not reach the cache until a reload
    u_mem.mem[8'h29] = 16'h7777;
    ref_chk(2'h2, 16'h0000, 24'h05_2000, 1'b0);
    mem_wait <= 4'h8;
    apb(1'b1, `OFF_SEL, 32'h0000_0010);
    apb(1'b1, `OFF_CMD, {28'h000_0000, 2'h2, `OP_LOAD_SEG});
    apb(1'b1, `OFF_SEL, 32'h0000_0020);
    rd_chk(`OFF_SEL, 32'h0000_0010);
    wait_done();
    ref_chk(2'h2, 16'h0000, 24'h05_7777, 1'b0);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk({31'h0000_0000, if_flag}, 32'h0000_0001);
    rd_chk(`OFF_GT_BASE, 32'h0000_0000);
    rd_chk(`OFF_LT_LIMIT, 32'h0000_0000);
    ref_chk(2'h2, 16'h0000, 24'h00_0000, 1'b1);
    end_sim();
  end
endmodule // descriptor_table_protection_tb_top
